// file: rtl/dcp_channel.sv
// dma channel sizing and byte progress tracking with register port and beat fifo
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dcp_regs.svh"

// What this block does
// - destination size is 16 bits; zero means 65,536 bytes, else N bytes.
// - destination size in bits 15-0, read and write, reset zero, upper bits read zero.
// - source pointer counts index of next source byte, 0 to 65,535.
// - destination pointer counts index of next destination byte, 0 to 65,535.
// - pointer registers are read-only, bits 15-0, upper zero, reset zero.
// - cell size is 16 bits of bytes per trigger; zero means 65,536.
// - cell size in bits 15-0, read and write, reset zero, upper bits zero.
// - cell counter shows bytes moved since the latest trigger event.
// - in pattern mode a match clears source pointer and cell counter.
// - cell-complete flag sets when cell count reaches cell size.
// - block-complete flag sets when larger size is moved or on a match in pattern mode.
// - destination-done at full size, destination-half at half size.
// - source size is 16 bits; zero means 65,536 bytes.
module dcp_channel import dcp_pkg::*; #(
	parameter int DEPTH = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output var logic [31:0] o_rdata,
	input wire logic i_src_valid,
	input wire logic [31:0] i_src_data,
	input wire logic [2:0] i_src_bytes,
	output logic o_src_ready,
	output var logic o_dst_valid,
	output var logic [31:0] o_dst_data,
	output var logic [2:0] o_dst_bytes,
	input wire logic i_dst_ready,
	input wire logic i_cell_trigger,
	input wire logic i_pattern_match,
	output var logic [3:0] o_flags
);
	logic [15:0] dst_size_reg;
	logic [15:0] src_size_reg;
	logic [15:0] cell_size_reg;
	logic en_reg;
	logic pat_mode_reg;
	logic [31:0] rdata_next;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	dcp_count_t src_lim;
	dcp_count_t dst_lim;
	dcp_count_t cell_lim;
	dcp_count_t src_ptr;
	dcp_count_t dst_ptr;
	dcp_count_t cell_ptr;
	dcp_count_t src_sum;
	dcp_count_t dst_sum;
	dcp_count_t cell_sum;
	logic src_reach;
	logic dst_reach;
	logic dst_half;
	logic cell_reach;
	logic push;
	logic pop;
	logic dst_take;
	logic pat_hit;
	logic cell_clr;

	dcp_stream_if in_if ();
	dcp_stream_if out_if ();

	// source side feeds the fifo; ready comes straight from the fifo flop
	assign in_if.valid = i_src_valid;
	assign in_if.beat = '{data: i_src_data, bytes: i_src_bytes};
	assign o_src_ready = in_if.ready;
	// disabled channel keeps filling until the fifo pushes back on the source
	assign out_if.ready = en_reg & (!o_dst_valid | i_dst_ready);

	dcp_fifo #(
		.WIDTH($bits(dcp_beat_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.wr(in_if.snk),
		.rd(out_if.src)
	);

	// handshakes and size decoding
	assign push = i_src_valid & in_if.ready;
	assign pop = out_if.valid & out_if.ready;
	assign dst_take = o_dst_valid & i_dst_ready;
	assign pat_hit = pat_mode_reg & i_pattern_match;
	assign cell_clr = pat_hit | i_cell_trigger;
	assign src_lim = dcp_size_decode(src_size_reg);
	assign dst_lim = dcp_size_decode(dst_size_reg);
	assign cell_lim = dcp_size_decode(cell_size_reg);
	assign src_sum = src_ptr + dcp_count_t'(i_src_bytes);
	assign dst_sum = dst_ptr + dcp_count_t'(o_dst_bytes);
	assign cell_sum = cell_ptr + dcp_count_t'(o_dst_bytes);

	// source pointer counts bytes taken in, cleared by a pattern match
	dcp_ptr #(
		.WRAP(1'b1)
	) u_src_ptr (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clr(pat_hit),
		.i_add(push),
		.i_bytes(i_src_bytes),
		.i_limit(src_lim),
		.o_ptr(src_ptr),
		.o_reach(src_reach),
		.o_half()
	);

	// destination pointer counts bytes handed out
	dcp_ptr #(
		.WRAP(1'b1)
	) u_dst_ptr (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clr(1'b0),
		.i_add(dst_take),
		.i_bytes(o_dst_bytes),
		.i_limit(dst_lim),
		.o_ptr(dst_ptr),
		.o_reach(dst_reach),
		.o_half(dst_half)
	);

	// cell counter holds at the cell size until the next trigger or pattern-mode match
	dcp_ptr #(
		.WRAP(1'b0)
	) u_cell_ptr (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clr(cell_clr),
		.i_add(dst_take),
		.i_bytes(o_dst_bytes),
		.i_limit(cell_lim),
		.o_ptr(cell_ptr),
		.o_reach(cell_reach),
		.o_half()
	);

	// writable size and control registers; pointers have no write path
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			dst_size_reg <= `DCP_SIZE_RST;
			src_size_reg <= `DCP_SIZE_RST;
			cell_size_reg <= `DCP_SIZE_RST;
			en_reg <= 1'b0;
			pat_mode_reg <= 1'b0;
		end else if (i_wr) begin
			case (i_addr)
				`DCP_ADDR_DST_SIZE: begin
					dst_size_reg <= i_wdata[`DCP_FIELD_MSB:`DCP_FIELD_LSB];
				end
				`DCP_ADDR_SRC_SIZE: begin
					src_size_reg <= i_wdata[`DCP_FIELD_MSB:`DCP_FIELD_LSB];
				end
				`DCP_ADDR_CELL_SIZE: begin
					cell_size_reg <= i_wdata[`DCP_FIELD_MSB:`DCP_FIELD_LSB];
				end
				`DCP_ADDR_CTRL: begin
					en_reg <= i_wdata[`DCP_CTRL_EN];
					pat_mode_reg <= i_wdata[`DCP_CTRL_PAT];
				end
				default: begin
				end
			endcase
		end
	end

	// flag events; the larger size decides block end, equal sizes count on destination
	always_comb begin
		flag_set = 4'h0;
		flag_set[`DCP_FLAG_CELL] = cell_reach;
		flag_set[`DCP_FLAG_BLOCK] = ((dst_lim >= src_lim) ? dst_reach : src_reach) | pat_hit;
		flag_set[`DCP_FLAG_DDONE] = dst_reach;
		flag_set[`DCP_FLAG_DHALF] = dst_half;
		flag_clr = (i_wr && i_addr == `DCP_ADDR_FLAGS) ? i_wdata[3:0] : 4'h0;
	end

	// sticky flags, write one to clear; a new event wins over the clear
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_flags <= 4'h0;
		end else begin
			o_flags <= (o_flags & ~flag_clr) | flag_set;
		end
	end

	// read mux; the top half always reads zero
	always_comb begin
		rdata_next = `DCP_ZERO_WORD;
		case (i_addr)
			`DCP_ADDR_DST_SIZE: rdata_next = {`DCP_UPPER_ZERO, dst_size_reg};
			`DCP_ADDR_SRC_PTR: rdata_next = {`DCP_UPPER_ZERO, src_ptr[15:0]};
			`DCP_ADDR_DST_PTR: rdata_next = {`DCP_UPPER_ZERO, dst_ptr[15:0]};
			`DCP_ADDR_CELL_SIZE: rdata_next = {`DCP_UPPER_ZERO, cell_size_reg};
			`DCP_ADDR_CELL_PTR: rdata_next = {`DCP_UPPER_ZERO, cell_ptr[15:0]};
			`DCP_ADDR_SRC_SIZE: rdata_next = {`DCP_UPPER_ZERO, src_size_reg};
			`DCP_ADDR_CTRL: rdata_next = {30'h0000_0000, pat_mode_reg, en_reg};
			`DCP_ADDR_FLAGS: rdata_next = {28'h000_0000, o_flags};
			default: rdata_next = `DCP_ZERO_WORD;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_rdata <= `DCP_ZERO_WORD;
		end else begin
			o_rdata <= i_rd ? rdata_next : `DCP_ZERO_WORD;
		end
	end

	// output stage keeps the destination ports on flops
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_dst_valid <= 1'b0;
			o_dst_data <= `DCP_ZERO_WORD;
			o_dst_bytes <= 3'h0;
		end else if (pop) begin
			o_dst_valid <= 1'b1;
			o_dst_data <= out_if.beat.data;
			o_dst_bytes <= out_if.beat.bytes;
		end else if (i_dst_ready) begin
			o_dst_valid <= 1'b0;
		end
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence pat_hit_s;
		pat_mode_reg && i_pattern_match;
	endsequence

	sequence dst_end_s;
		dst_take && (dst_sum >= dst_lim);
	endsequence

	sequence cell_end_s;
		dst_take && !cell_clr && (cell_sum >= cell_lim);
	endsequence

	dsize_read_a: assert property (
		i_rd && i_addr == `DCP_ADDR_DST_SIZE |=> o_rdata == {16'h0000, $past(dst_size_reg)})
		else $error("destination size read back wrong");

	csize_read_a: assert property (
		i_rd && i_addr == `DCP_ADDR_CELL_SIZE |=> o_rdata == {16'h0000, $past(cell_size_reg)})
		else $error("cell size read back wrong");

	ptr_upper_a: assert property (
		i_rd && (i_addr == `DCP_ADDR_SRC_PTR || i_addr == `DCP_ADDR_DST_PTR || i_addr == `DCP_ADDR_CELL_PTR)
		|=> o_rdata[31:16] == 16'h0000)
		else $error("pointer upper half not zero");

	ptr_readonly_a: assert property (
		i_wr && i_addr == `DCP_ADDR_DST_PTR && !dst_take |=> $stable(dst_ptr))
		else $error("destination pointer changed by a write");

	src_step_a: assert property (
		push && !pat_hit && src_sum < src_lim |=> src_ptr == $past(src_sum))
		else $error("source pointer did not advance by beat bytes");

	src_wrap_a: assert property (
		push && !pat_hit && src_sum >= src_lim |=> src_ptr == 17'h0_0000 && src_reach)
		else $error("source pointer did not wrap at source size");

	dst_step_a: assert property (
		dst_take && dst_sum < dst_lim |=> dst_ptr == $past(dst_sum))
		else $error("destination pointer did not advance by beat bytes");

	pat_clear_a: assert property (
		pat_hit_s |=> src_ptr == 17'h0_0000 && cell_ptr == 17'h0_0000 && o_flags[`DCP_FLAG_BLOCK])
		else $error("pattern match did not clear pointers or set block flag");

	cell_flag_a: assert property (
		cell_end_s |-> ##2 o_flags[`DCP_FLAG_CELL])
		else $error("cell-complete flag missing");

	dst_done_a: assert property (
		dst_end_s |=> dst_ptr == 17'h0_0000 ##1 o_flags[`DCP_FLAG_DDONE])
		else $error("destination-done flag missing");

	cell_trig_a: assert property (
		i_cell_trigger |=> cell_ptr == 17'h0_0000)
		else $error("trigger did not restart cell count");

	zero_size_a: assert property (
		dst_size_reg == 16'h0000 && dst_take && dst_ptr == 17'h0_0000 |=> dst_ptr != 17'h0_0000)
		else $error("zero destination size treated as empty");

endmodule

`default_nettype wire

// file: rtl/dcp_fifo.sv
// beat fifo with registered full and empty, sits between source and destination sides
`timescale 1ns/10ps
`default_nettype none

module dcp_fifo import dcp_pkg::*; #(
	parameter int WIDTH = $bits(dcp_beat_t),
	parameter int DEPTH = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	dcp_stream_if.snk wr,
	dcp_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic ready_reg;
	logic valid_reg;
	logic push;
	logic pop;

	// ready and valid are flops so the ports see no combinational path
	assign wr.ready = ready_reg;
	assign rd.valid = valid_reg;
	assign rd.beat = dcp_beat_t'(mem[rd_ptr_reg]);
	assign push = wr.valid & ready_reg;
	assign pop = rd.ready & valid_reg;
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	// storage, no reset needed on the data words
	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= WIDTH'(wr.beat);
		end
	end

	// pointers and fill level
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			count_reg <= count_next;
			ready_reg <= count_next < (AW+1)'(DEPTH);
			valid_reg <= count_next != '0;
		end
	end

	// ready is still low in the first cycle out of reset, so the check starts one cycle later
	fifo_level_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(i_rst_n) |-> count_reg <= (AW+1)'(DEPTH) && (ready_reg == (count_reg != (AW+1)'(DEPTH))))
		else $error("fifo level or ready out of step");

endmodule

`default_nettype wire

// file: rtl/dcp_pkg.sv
// types and size decoding for the dma channel size and pointer block
package dcp_pkg;

	// one bus beat: data and the number of valid bytes, 1 to 4
	typedef struct packed {
		logic [31:0] data;
		logic [2:0] bytes;
	} dcp_beat_t;

	// byte counts reach 65,536, so they need 17 bits
	typedef logic [16:0] dcp_count_t;

	// all-zero size field stands for 65,536 bytes
	function automatic dcp_count_t dcp_size_decode(input logic [15:0] field);
		dcp_size_decode = (field == 16'h0000) ? 17'h1_0000 : {1'b0, field};
	endfunction

endpackage

// file: rtl/dcp_ptr.sv
// byte progress counter with wrap or hold at its limit
`timescale 1ns/10ps
`default_nettype none

module dcp_ptr import dcp_pkg::*; #(
	parameter bit WRAP = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clr,
	input wire logic i_add,
	input wire logic [2:0] i_bytes,
	input wire dcp_count_t i_limit,
	output var dcp_count_t o_ptr,
	output var logic o_reach,
	output var logic o_half
);
	dcp_count_t sum;
	dcp_count_t half_lim;
	logic reach;
	logic half;

	// beats of up to four bytes may step over the exact midpoint, so test the crossing
	assign sum = o_ptr + dcp_count_t'(i_bytes);
	assign half_lim = i_limit >> 1;
	assign reach = i_add && (sum >= i_limit);
	assign half = i_add && (o_ptr < half_lim) && (sum >= half_lim);

	// clear beats a simultaneous beat: a matched pattern restarts counting
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_ptr <= `DCP_PTR_RST;
			o_reach <= 1'b0;
			o_half <= 1'b0;
		end else begin
			if (i_clr) begin
				o_ptr <= `DCP_PTR_RST;
			end else if (reach) begin
				o_ptr <= WRAP ? `DCP_PTR_RST : i_limit;
			end else if (i_add) begin
				o_ptr <= sum;
			end
			o_reach <= reach && !i_clr;
			o_half <= half && !i_clr;
		end
	end

endmodule

`default_nettype wire

// file: rtl/dcp_regs.svh
// register offsets, field positions and reset values of the dma channel size and pointer block
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH

// register byte offsets on the plain register port
`define DCP_ADDR_DST_SIZE 8'h00
`define DCP_ADDR_SRC_PTR 8'h04
`define DCP_ADDR_DST_PTR 8'h08
`define DCP_ADDR_CELL_SIZE 8'h0C
`define DCP_ADDR_CELL_PTR 8'h10
`define DCP_ADDR_SRC_SIZE 8'h14
`define DCP_ADDR_CTRL 8'h18
`define DCP_ADDR_FLAGS 8'h1C

// field layout shared by all size and pointer registers
`define DCP_FIELD_MSB 15
`define DCP_FIELD_LSB 0
`define DCP_UPPER_ZERO 16'h0000

// reset values
`define DCP_SIZE_RST 16'h0000
`define DCP_PTR_RST 17'h0_0000
`define DCP_ZERO_WORD 32'h0000_0000

// control bits
`define DCP_CTRL_EN 0
`define DCP_CTRL_PAT 1

// flag bits, write one to clear
`define DCP_FLAG_CELL 0
`define DCP_FLAG_BLOCK 1
`define DCP_FLAG_DDONE 2
`define DCP_FLAG_DHALF 3

`endif

// file: rtl/dcp_stream_if.sv
// valid and ready beat stream between the channel and its fifo
`timescale 1ns/10ps
`default_nettype none

interface dcp_stream_if;
	import dcp_pkg::*;
	logic valid;
	logic ready;
	dcp_beat_t beat;
	modport src(output valid, output beat, input ready);
	modport snk(input valid, input beat, output ready);
endinterface

`default_nettype wire

// file: test/dcp_bus_model.sv
// bus-side model: beat source that holds until taken, and a sink that can stall
`timescale 1ns/10ps
`default_nettype none

module dcp_bus_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic [5:0] i_count,
	input wire logic [2:0] i_bytes,
	input wire logic i_stall,
	input wire logic i_src_ready,
	output var logic o_src_valid,
	output var logic [31:0] o_src_data,
	output var logic [2:0] o_src_bytes,
	input wire logic i_dst_valid,
	input wire logic [2:0] i_dst_bytes,
	output var logic o_dst_ready,
	output var logic o_busy,
	output var logic [15:0] o_got
);
	logic [5:0] left_reg;
	logic [31:0] seq_reg;

	assign o_busy = (left_reg != 6'h00) || o_src_valid;

	// a beat stands until taken and carries its running number; idle data toggles
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			left_reg <= 6'h00;
			seq_reg <= 32'h0000_0000;
			o_src_valid <= 1'b0;
			o_src_data <= 32'h0000_0000;
			o_src_bytes <= 3'h1;
		end else if (i_load) begin
			left_reg <= i_count;
		end else if (!o_src_valid || i_src_ready) begin
			o_src_valid <= (left_reg != 6'h00);
			o_src_data <= (left_reg != 6'h00) ? seq_reg : ~o_src_data;
			seq_reg <= (left_reg != 6'h00) ? seq_reg + 32'h0000_0001 : seq_reg;
			o_src_bytes <= i_bytes;
			left_reg <= (left_reg != 6'h00) ? left_reg - 6'h01 : left_reg;
		end
	end

	// sink counts bytes it takes; ready registered like a slow memory port
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_dst_ready <= 1'b0;
			o_got <= 16'h0000;
		end else begin
			o_dst_ready <= !i_stall;
			if (i_dst_valid && o_dst_ready) begin
				o_got <= o_got + {13'h0000, i_dst_bytes};
			end
		end
	end
endmodule

`default_nettype wire

// file: test/test_dcp_channel.sv
// self-checking bench for the dma channel size and pointer block
`timescale 1ns/10ps
`default_nettype none
`include "dcp_regs.svh"

module test_dcp_channel;
	logic clk, rst_n, wr_s, rd_s, load, stall, trig, match;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, sdata, ddata;
	logic [2:0] sbytes, dbytes, bytes;
	logic [5:0] count;
	logic svalid, sready, dvalid, dready, busy;
	logic [3:0] flags;
	logic [15:0] got;
	int n_errors = 0;
	int checks_done = 0;

	dcp_channel #(.DEPTH(16)) i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_src_valid(svalid), .i_src_data(sdata),
		.i_src_bytes(sbytes), .o_src_ready(sready), .o_dst_valid(dvalid), .o_dst_data(ddata),
		.o_dst_bytes(dbytes), .i_dst_ready(dready), .i_cell_trigger(trig), .i_pattern_match(match),
		.o_flags(flags));

	dcp_bus_model i_bus (.i_ref_clk(clk), .i_rst_n(rst_n), .i_load(load), .i_count(count),
		.i_bytes(bytes), .i_stall(stall), .i_src_ready(sready), .o_src_valid(svalid),
		.o_src_data(sdata), .o_src_bytes(sbytes), .i_dst_valid(dvalid), .i_dst_bytes(dbytes),
		.o_dst_ready(dready), .o_busy(busy), .o_got(got));

	// free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk($sformatf("register %h", a), rdata, exp);
	endtask

	task automatic pulse(input bit is_trig);
		@(posedge clk);
		trig <= is_trig;
		match <= !is_trig;
		@(posedge clk);
		trig <= 1'b0;
		match <= 1'b0;
	endtask

	task automatic send(input logic [5:0] n, input logic [2:0] b);
		@(posedge clk);
		load <= 1'b1;
		count <= n;
		bytes <= b;
		@(posedge clk);
		load <= 1'b0;
	endtask

	// bounded wait for the sink total, then room for the two-cycle flag path
	task automatic wait_got(input logic [15:0] exp, input logic [31:0] exp_data);
		for (int i = 0; i < 300 && got !== exp; i++) @(posedge clk);
		repeat (3) @(posedge clk);
		#1;
		chk("sink bytes", {16'h0000, got}, {16'h0000, exp});
		chk("last data", ddata, exp_data);
		chk("model idle", {31'h0, busy}, 32'h0000_0000);
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a hang is cut short well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		test_done();
	end

	initial begin
		logic [7:0] map[9];
		map = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
		{rst_n, wr_s, rd_s, load, stall, trig, match} = 7'h00;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		count = 6'h00;
		bytes = 3'h1;
		do_reset();
		// reset values, upper bits, read-only pointers, unmapped place
		for (int i = 0; i < 9; i++) rd(map[i], 32'h0000_0000);
		wr(`DCP_ADDR_DST_SIZE, 32'hFFFF_ABCD);
		rd(`DCP_ADDR_DST_SIZE, 32'h0000_ABCD);
		wr(`DCP_ADDR_CELL_SIZE, 32'h1234_5678);
		rd(`DCP_ADDR_CELL_SIZE, 32'h0000_5678);
		wr(`DCP_ADDR_SRC_PTR, 32'h0000_0055);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0000);
		wr(`DCP_ADDR_DST_PTR, 32'h0000_0066);
		rd(`DCP_ADDR_DST_PTR, 32'h0000_0000);
		wr(`DCP_ADDR_SRC_SIZE, 32'hFFFF_1357);
		rd(`DCP_ADDR_SRC_SIZE, 32'h0000_1357);
		wr(`DCP_ADDR_SRC_SIZE, 32'h0000_0000);
		wr(`DCP_ADDR_DST_SIZE, 32'h0000_0000);
		wr(`DCP_ADDR_CELL_SIZE, 32'h0000_0000);
		$display("test registers done");
		// drain off: buffer fills and refuses, then holds for a stalled sink and drains once the stall lifts
		send(6'd20, 3'h1);
		repeat (40) @(posedge clk);
		chk("source ready", {31'h0, sready}, 32'h0000_0000);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0010);
		@(posedge clk);
		stall <= 1'b1;
		wr(`DCP_ADDR_CTRL, 32'h0000_0001);
		repeat (10) @(posedge clk);
		rd(`DCP_ADDR_DST_PTR, 32'h0000_0000);
		@(posedge clk);
		stall <= 1'b0;
		wait_got(16'd20, 32'h0000_0013);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0014);
		rd(`DCP_ADDR_DST_PTR, 32'h0000_0014);
		rd(`DCP_ADDR_CELL_PTR, 32'h0000_0014);
		chk("flags", {28'h0, flags}, 32'h0000_0000);
		$display("test buffer done");
		// second reset, then small sizes so the flags and wraps show
		do_reset();
		wr(`DCP_ADDR_DST_SIZE, 32'h0000_0008);
		wr(`DCP_ADDR_SRC_SIZE, 32'h0000_0008);
		wr(`DCP_ADDR_CELL_SIZE, 32'h0000_0004);
		wr(`DCP_ADDR_CTRL, 32'h0000_0001);
		send(6'd1, 3'h3);
		wait_got(16'd3, 32'h0000_0000);
		pulse(1'b0);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0003);
		rd(`DCP_ADDR_CELL_PTR, 32'h0000_0003);
		send(6'd1, 3'h1);
		wait_got(16'd4, 32'h0000_0001);
		chk("flags", {28'h0, flags}, 32'h0000_0009);
		rd(`DCP_ADDR_CELL_PTR, 32'h0000_0004);
		pulse(1'b1);
		wr(`DCP_ADDR_FLAGS, 32'h0000_000F);
		rd(`DCP_ADDR_CELL_PTR, 32'h0000_0000);
		chk("flags", {28'h0, flags}, 32'h0000_0000);
		send(6'd1, 3'h4);
		wait_got(16'd8, 32'h0000_0002);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0000);
		rd(`DCP_ADDR_DST_PTR, 32'h0000_0000);
		chk("flags", {28'h0, flags}, 32'h0000_0007);
		$display("test tracking done");
		// pattern mode: a match clears source and cell, leaves destination
		wr(`DCP_ADDR_FLAGS, 32'h0000_000F);
		pulse(1'b1);
		wr(`DCP_ADDR_CTRL, 32'h0000_0003);
		send(6'd1, 3'h2);
		wait_got(16'd10, 32'h0000_0003);
		rd(`DCP_ADDR_CELL_PTR, 32'h0000_0002);
		pulse(1'b0);
		@(posedge clk);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0000);
		rd(`DCP_ADDR_CELL_PTR, 32'h0000_0000);
		rd(`DCP_ADDR_DST_PTR, 32'h0000_0002);
		chk("flags", {28'h0, flags}, 32'h0000_0002);
		$display("test pattern done");
		// destination smaller than source: done flag only, block end waits for the source
		wr(`DCP_ADDR_FLAGS, 32'h0000_000F);
		wr(`DCP_ADDR_DST_SIZE, 32'h0000_0004);
		wr(`DCP_ADDR_SRC_SIZE, 32'h0000_0010);
		send(6'd1, 3'h2);
		wait_got(16'd12, 32'h0000_0004);
		rd(`DCP_ADDR_DST_PTR, 32'h0000_0000);
		rd(`DCP_ADDR_SRC_PTR, 32'h0000_0002);
		chk("flags", {28'h0, flags}, 32'h0000_0004);
		$display("test larger size done");
		test_done();
	end
endmodule

`default_nettype wire
